// File: design/nsld_pkg.sv
package nsld_pkg;

  // ------------------------------------------------------------
  // protocol selection and indicator codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    NSLD_PROTO_EIP  = 2'h0,
    NSLD_PROTO_MTCP = 2'h1,
    NSLD_PROTO_PNET = 2'h2
  } nsld_proto_t;

  typedef struct packed {
    logic red;
    logic green;
  } nsld_led_t;

  typedef struct packed {
    logic [2:0] conn_count;
    logic       eth_link;
    logic       cip_open;
    logic       dup_ip;
    logic       name_mismatch;
    logic       ioc_conn;
    logic       ioc_run;
    logic       selftest;
  } nsld_stat_t;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int NSLD_CLK_HZ       = 10_000_000;
  localparam int NSLD_FLASH_MS     = 250;
  localparam int NSLD_PAUSE_MS     = 2000;
  localparam int NSLD_FLASH_CYC    = NSLD_CLK_HZ / 1000 * NSLD_FLASH_MS;
  localparam int NSLD_PAUSE_CYC    = NSLD_CLK_HZ / 1000 * NSLD_PAUSE_MS;
  localparam int NSLD_CNT_W        = 26;
  localparam logic [2:0] NSLD_MAX_CONN = 3'h5;

endpackage

// File: design/nsld_timer.sv
`timescale 1ns/1ps
module nsld_timer
#(
  parameter int FLASH_CYC = nsld_pkg::NSLD_FLASH_CYC
)
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_en,
  output logic      o_tick
);

  logic [nsld_pkg::NSLD_CNT_W-1:0] cnt_r;
  localparam logic [nsld_pkg::NSLD_CNT_W-1:0] LAST =
    nsld_pkg::NSLD_CNT_W'(FLASH_CYC - 1);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_r <= '0;
    else if (i_en)
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
  end

  assign o_tick = i_en && (cnt_r == LAST);

endmodule

// File: design/nsld_top.sv
`timescale 1ns/1ps
module nsld_top
#(
  parameter int FLASH_CYC = nsld_pkg::NSLD_FLASH_CYC,
  parameter int PAUSE_CYC = nsld_pkg::NSLD_PAUSE_CYC
)
(
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_ce,
  input  wire nsld_pkg::nsld_proto_t i_proto,
  input  wire nsld_pkg::nsld_stat_t  i_stat,
  input  wire logic                 i_mod_green,
  input  wire logic                 i_timeout,
  input  wire logic                 i_cfg_change,
  output nsld_pkg::nsld_led_t       o_net_led,
  output logic                      o_mod_red_flash
);

  // ------------------------------------------------------------
  // flash time base
  // ------------------------------------------------------------
  logic tick;
  logic phase_r;

  nsld_timer #(.FLASH_CYC(FLASH_CYC)) u_timer
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_en   (i_ce),
    .o_tick (tick)
  );

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      phase_r <= 1'b0;
    else if (tick)
      phase_r <= ~phase_r;
  end

  // ------------------------------------------------------------
  // sticky faults: config fault held until reset, timeout latch clears on cip open or loss of module green
  // ------------------------------------------------------------
  logic cfg_r;
  logic tmo_r;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cfg_r <= 1'b0;
    else if (i_ce && i_cfg_change)
      cfg_r <= 1'b1;
  end

  // timeout latch clears once a cip connection comes back
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      tmo_r <= 1'b0;
    else if (i_ce)
    begin
      if (i_timeout && i_mod_green)
        tmo_r <= 1'b1;
      else if (i_stat.cip_open || !i_mod_green)
        tmo_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // modbus flash groups
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    NSLD_GRP_IDLE,
    NSLD_GRP_FLASH,
    NSLD_GRP_PAUSE
  } nsld_grp_t;

  nsld_grp_t                        grp_r;
  logic [2:0]                       left_r;
  logic [nsld_pkg::NSLD_CNT_W-1:0]  pause_r;
  logic [2:0]                       conns;
  localparam logic [nsld_pkg::NSLD_CNT_W-1:0] PAUSE_LAST =
    nsld_pkg::NSLD_CNT_W'(PAUSE_CYC - 1);

  // clamp to the supported connection limit
  assign conns = (i_stat.conn_count > nsld_pkg::NSLD_MAX_CONN) ?
                 nsld_pkg::NSLD_MAX_CONN : i_stat.conn_count;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      grp_r   <= NSLD_GRP_IDLE;
      left_r  <= 3'h0;
      pause_r <= '0;
    end
    else if (i_ce)
    begin
      case (grp_r)
        NSLD_GRP_IDLE:
        begin
          pause_r <= '0;
          // start on an off phase edge so each flash is full width
          if (conns != 3'h0 && tick && phase_r)
          begin
            grp_r  <= NSLD_GRP_FLASH;
            left_r <= conns;
          end
        end
        NSLD_GRP_FLASH:
        begin
          if (conns == 3'h0)
            grp_r <= NSLD_GRP_IDLE;
          else if (tick && phase_r)
          begin
            if (left_r == 3'h1)
              grp_r <= NSLD_GRP_PAUSE;
            left_r <= left_r - 3'h1;
          end
        end
        NSLD_GRP_PAUSE:
        begin
          if (pause_r == PAUSE_LAST)
          begin
            pause_r <= '0;
            grp_r   <= NSLD_GRP_IDLE;
          end
          else
            pause_r <= pause_r + 1'b1;
        end
        default:
          grp_r <= NSLD_GRP_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pattern selection
  // ------------------------------------------------------------
  nsld_pkg::nsld_led_t led_nxt;
  nsld_pkg::nsld_led_t led_r;

  always_comb
  begin
    led_nxt = '0;
    if (i_stat.selftest)
    begin
      led_nxt.red   = phase_r;
      led_nxt.green = ~phase_r;
    end
    else if (cfg_r)
      led_nxt.red = phase_r;
    else
    begin
      case (i_proto)
        nsld_pkg::NSLD_PROTO_EIP:
        begin
          if (i_stat.dup_ip)
            led_nxt.red = 1'b1;
          else if (tmo_r)
            led_nxt.red = phase_r;
          else if (i_stat.eth_link && i_stat.cip_open)
            led_nxt.green = 1'b1;
          else if (i_stat.eth_link)
            led_nxt.green = phase_r;
        end
        nsld_pkg::NSLD_PROTO_MTCP:
          // off when idle, never steady green
          // gate on conns too: a group in flight must not outlive the last connection
          led_nxt.green = (grp_r == NSLD_GRP_FLASH) && phase_r
                          && (conns != 3'h0);
        nsld_pkg::NSLD_PROTO_PNET:
        begin
          if (i_stat.dup_ip || i_stat.name_mismatch || !i_stat.ioc_conn)
            led_nxt.green = 1'b0;
          else if (i_stat.ioc_run)
            led_nxt.green = 1'b1;
          else
            led_nxt.green = phase_r;
        end
        default:
          led_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      led_r <= '0;
    else if (i_ce)
      led_r <= led_nxt;
  end

  assign o_net_led       = led_r;
  assign o_mod_red_flash = cfg_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_cfg_sticky: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    cfg_r |=> cfg_r) else $error("config fault cleared");

  a_cfg_no_green: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && cfg_r && !i_stat.selftest) |=> !o_net_led.green)
    else $error("green during config fault");

  a_cfg_flash: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && cfg_r && !i_stat.selftest) |=> o_net_led.red == $past(phase_r))
    else $error("config fault not flashing red");

  a_mod_red: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_cfg_change) |=> o_mod_red_flash)
    else $error("module red flash not raised");

  a_mtcp_off: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto == nsld_pkg::NSLD_PROTO_MTCP && conns == 3'h0
     && !cfg_r && !i_stat.selftest) |=> !o_net_led.green && !o_net_led.red)
    else $error("modbus led not off");

  a_grp_limit: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    left_r <= nsld_pkg::NSLD_MAX_CONN) else $error("group too long");

  a_grp_start: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && grp_r == NSLD_GRP_IDLE && conns != 3'h0 && tick && phase_r)
    |=> grp_r == NSLD_GRP_FLASH && left_r == $past(conns))
    else $error("flash group not started");

  a_mtcp_nosteady: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_proto == nsld_pkg::NSLD_PROTO_MTCP && grp_r != NSLD_GRP_FLASH
     && !cfg_r && !i_stat.selftest && i_ce) |=> !o_net_led.green)
    else $error("modbus green outside flash");

  a_pause_idle: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && grp_r == NSLD_GRP_PAUSE && pause_r == PAUSE_LAST)
    |=> grp_r == NSLD_GRP_IDLE) else $error("pause not ended");

  a_eip_dup: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto == nsld_pkg::NSLD_PROTO_EIP && i_stat.dup_ip
     && !cfg_r && !i_stat.selftest) |=> o_net_led.red && !o_net_led.green)
    else $error("duplicate address not red");

  a_eip_cip: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto == nsld_pkg::NSLD_PROTO_EIP && !i_stat.dup_ip && !tmo_r
     && i_stat.eth_link && i_stat.cip_open && !cfg_r && !i_stat.selftest)
    |=> o_net_led.green) else $error("cip not steady green");

  a_eip_link: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto == nsld_pkg::NSLD_PROTO_EIP && !i_stat.dup_ip && !tmo_r
     && i_stat.eth_link && !i_stat.cip_open && !cfg_r && !i_stat.selftest)
    |=> o_net_led.green == $past(phase_r) && !o_net_led.red)
    else $error("link without cip not flashing green");

  a_eip_tmo: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto == nsld_pkg::NSLD_PROTO_EIP && !i_stat.dup_ip && tmo_r
     && !cfg_r && !i_stat.selftest)
    |=> o_net_led.red == $past(phase_r) && !o_net_led.green)
    else $error("timeout not flashing red");

  a_red_eip_only: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto != nsld_pkg::NSLD_PROTO_EIP && !cfg_r
     && !i_stat.selftest) |=> !o_net_led.red)
    else $error("red outside ethernet/ip");

  a_pnet_off: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto == nsld_pkg::NSLD_PROTO_PNET && !i_stat.ioc_conn
     && !cfg_r && !i_stat.selftest) |=> !o_net_led.green && !o_net_led.red)
    else $error("profinet not off");

  a_pnet_stop: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto == nsld_pkg::NSLD_PROTO_PNET && i_stat.ioc_conn
     && !i_stat.ioc_run && !i_stat.dup_ip && !i_stat.name_mismatch
     && !cfg_r && !i_stat.selftest)
    |=> o_net_led.green == $past(phase_r) && !o_net_led.red)
    else $error("profinet stop not flashing green");

  a_pnet_run: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_proto == nsld_pkg::NSLD_PROTO_PNET && i_stat.ioc_conn
     && i_stat.ioc_run && !i_stat.dup_ip && !i_stat.name_mismatch
     && !cfg_r && !i_stat.selftest) |=> o_net_led.green)
    else $error("profinet run not green");

  a_tmo_qual: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !i_mod_green) |=> !tmo_r)
    else $error("timeout without module green");

  a_tmo_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_timeout && i_mod_green) |=> tmo_r)
    else $error("timeout not latched");

  a_ce_freeze: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !i_ce |=> $stable(o_net_led) && $stable(grp_r) && $stable(phase_r))
    else $error("state moved while disabled");

endmodule

// File: tb/nsld_led_watch.sv
`timescale 1ns/1ps
module nsld_led_watch
#(
  parameter int OFF_GAP = 10
)
(
  input  wire logic                i_clk,
  input  wire logic                i_nrst,
  input  wire nsld_pkg::nsld_led_t i_led,
  output logic [3:0]               o_last_group
);
  // ----------------------------------------------------------
  // operator's eye: green pulses per group
  // ----------------------------------------------------------
  // a dark run reaching OFF_GAP cycles closes a group
  logic       prev_g_r;
  logic [3:0] cnt_r;
  logic [4:0] off_r;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      prev_g_r     <= 1'b0;
      cnt_r        <= 4'h0;
      off_r        <= 5'h0;
      o_last_group <= 4'h0;
    end
    else
    begin
      prev_g_r <= i_led.green;
      off_r    <= i_led.green ? 5'h0 : (off_r == 5'h1f ? off_r : off_r + 5'h1);
      if (i_led.green && !prev_g_r && cnt_r != 4'hf)
        cnt_r <= cnt_r + 4'h1;
      if (off_r == 5'(OFF_GAP) && cnt_r != 4'h0)
      begin
        o_last_group <= cnt_r;
        cnt_r        <= 4'h0;
      end
    end
  end
endmodule

// File: tb/tb_network_status_led_driver.sv
`timescale 1ns/1ps
module tb_network_status_led_driver;
  localparam int FC  = 4;
  localparam int WIN = 40;
  logic                  clk, nrst, ce, mod_green, tmo, cfg, mod_red;
  nsld_pkg::nsld_proto_t proto;
  nsld_pkg::nsld_stat_t  stat;
  nsld_pkg::nsld_led_t   led;
  logic [3:0]            grp, got;
  logic [31:0]           r;
  int                    failures, num_checks, cyc, seed, k;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  nsld_top #(.FLASH_CYC(FC), .PAUSE_CYC(20)) uut (.i_clk(clk),
    .i_nrst(nrst), .i_ce(ce), .i_proto(proto), .i_stat(stat),
    .i_mod_green(mod_green), .i_timeout(tmo), .i_cfg_change(cfg),
    .o_net_led(led), .o_mod_red_flash(mod_red));
  nsld_led_watch #(.OFF_GAP(2 * FC + 2)) eye (.i_clk(clk), .i_nrst(nrst),
    .i_led(led), .o_last_group(grp));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // codes: 0 off, 1 steady green, 2 flash green, 3 steady red, 4 flash red
  // 6 alternating red/green
  task automatic close_out();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  // window long enough to span a full modbus pause plus phase wait
  task automatic look(output logic [3:0] code);
    int   gc, rc, gt, rt, xu;
    logic pg, pr;
    gc = 0; rc = 0; gt = 0; rt = 0; xu = 0;
    step(3);
    pg = led.green;
    pr = led.red;
    repeat (WIN)
    begin
      step(1);
      gc += int'(led.green === 1'b1);
      rc += int'(led.red === 1'b1);
      gt += int'(led.green !== pg);
      rt += int'(led.red !== pr);
      xu += int'($isunknown(led));
      pg = led.green;
      pr = led.red;
    end
    code = (xu > 0) ? 4'h7 : (gc == WIN && rc == 0) ? 4'h1 :
           (rc == WIN && gc == 0) ? 4'h3 : (gc == 0 && rc == 0) ? 4'h0 :
           (rt > 0 && gc == 0) ? 4'h4 : (gt > 0 && rc == 0) ? 4'h2 :
           (gt > 0 && rt > 0) ? 4'h6 : 4'h7;
  endtask

  function automatic logic [3:0] want(nsld_pkg::nsld_proto_t p,
                                      nsld_pkg::nsld_stat_t s);
    if (p == nsld_pkg::NSLD_PROTO_EIP)
      return s.dup_ip ? 4'h3 : s.cip_open ? 4'h1 : s.eth_link ? 4'h2 : 4'h0;
    if (p == nsld_pkg::NSLD_PROTO_MTCP)
      return (s.conn_count == 3'h0) ? 4'h0 : 4'h2;
    if (s.dup_ip || s.name_mismatch || !s.ioc_conn)
      return 4'h0;
    return s.ioc_run ? 4'h1 : 4'h2;
  endfunction

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      failures++;
      close_out();
    end
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    seed = 26; nrst = 1'b0; ce = 1'b1; mod_green = 1'b0; tmo = 1'b0;
    cfg = 1'b0; proto = nsld_pkg::NSLD_PROTO_EIP; stat = '0;
    step(6);
    nrst = 1'b1;
    for (k = 0; k < 24; k++)
    begin
      r = $random(seed);
      stat = r[9:0];
      stat.selftest = 1'b0;
      stat.cip_open = stat.cip_open & stat.eth_link;
      stat.ioc_run = stat.ioc_run & stat.ioc_conn;
      r = $unsigned($random(seed)) % 3;
      proto = nsld_pkg::nsld_proto_t'(r[1:0]);
      look(got);
      chk(want(proto, stat), got);
    end
    $display("test random done");
    proto = nsld_pkg::NSLD_PROTO_MTCP;
    stat = '0;
    stat.eth_link = 1'b1;
    for (k = 0; k < 8; k++)
    begin
      stat.conn_count = 3'(k);
      look(got);
      chk(want(proto, stat), got);
      step(150);
      if (k > 0)
        chk((k > 5) ? 4'h5 : 4'(k), grp);
    end
    $display("test modbus done");
    proto = nsld_pkg::NSLD_PROTO_EIP;
    stat.conn_count = 3'h0;
    tmo = 1'b1;
    step(1);
    tmo = 1'b0;
    look(got);
    chk(4'h2, got);
    mod_green = 1'b1;
    tmo = 1'b1;
    step(1);
    tmo = 1'b0;
    look(got);
    chk(4'h4, got);
    mod_green = 1'b0;
    look(got);
    chk(4'h2, got);
    $display("test timeout done");
    cfg = 1'b1;
    step(1);
    cfg = 1'b0;
    proto = nsld_pkg::NSLD_PROTO_PNET;
    stat.ioc_conn = 1'b1;
    stat.ioc_run = 1'b1;
    look(got);
    chk(4'h4, got);
    chk(4'h1, {3'h0, mod_red});
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    look(got);
    chk(4'h1, got);
    chk(4'h0, {3'h0, mod_red});
    $display("test config done");
    stat.selftest = 1'b1;
    look(got);
    chk(4'h6, got);
    stat.selftest = 1'b0;
    proto = nsld_pkg::nsld_proto_t'(2'h3);
    look(got);
    chk(4'h0, got);
    proto = nsld_pkg::NSLD_PROTO_PNET;
    look(got);
    chk(4'h1, got);
    ce = 1'b0;
    stat.ioc_conn = 1'b0;
    look(got);
    chk(4'h1, got);
    ce = 1'b1;
    look(got);
    chk(4'h0, got);
    $display("test enable done");
    close_out();
  end
endmodule
